/* File: lcdc_decoder.v */
// command and data decoder of the lcd controller
`include "lcdc_consts.vh"

// Behaviour
// - indicator off single byte; on needs mode
// - mode byte low bits set indicator mode
// - nop changes nothing
// - display off then entire on: power save
// - mux ratio is value plus two
// - bias, slope, trim fields in one byte
// - quarter bias bit forces 1/4 bias
// - frame phases field in bits 5:4
// - display offset six bits, reset zero
// - status busy, segmap, display off, then bit 4 fixed at zero
// - status low nibble is fixed id
// - read advances column unless rmw mode or dummy read
// - first read after address is dummy
// - data write stores and advances column
// - column increment saturates at 131
// - two commands load column nibbles
// - start line register holds 0 to 63
// - contrast is opcode then six-bit value
// - power bits switch three supply circuits
// - bit0 buffer, bit1 regulator, bit2 booster
// - rmw exit restores saved column
// - sleep if indicator off else standby
module lcdc_decoder (
  input  wire       mclk,
  input  wire       rstn,
  input  wire       external_clear_pin_n,
  input  wire       host_stb,
  input  wire       host_dc,
  input  wire       host_rd,
  input  wire [7:0] host_wdata,
  output reg  [7:0] host_rdata,
  output reg        host_rvalid,
  output reg        host_busy,
  output reg  [7:0] mem_addr,
  output reg  [3:0] mem_page,
  output reg  [7:0] mem_wdata,
  output reg        mem_we,
  input  wire [7:0] mem_rdata,
  output reg        pwr_buffer,
  output reg        pwr_regulator,
  output reg        pwr_booster,
  output reg  [1:0] static_icon_drive,
  output reg        sleep_mode,
  output reg        standby_mode,
  output reg  [6:0] mux_ratio,
  output reg  [5:0] disp_offset,
  output reg  [5:0] start_line,
  output reg  [5:0] contrast,
  output reg  [1:0] bias_sel,
  output reg        bias_alt,
  output reg        bias_quarter,
  output reg  [2:0] temperature_slope,
  output reg  [2:0] osc_trim,
  output reg  [1:0] frame_phase,
  output reg  [2:0] internal_ladder_select,
  output reg        disp_on,
  output reg        entire_on,
  output reg        disp_reverse,
  output reg        seg_remap,
  output reg        com_remap
);
  // ==========================================
  // pin synchronisers and host fifo
  reg  [2:0]  stb_sync_reg;
  reg  [1:0]  clr_sync_reg;
  reg  [9:0]  word_s1_reg;
  reg  [9:0]  word_s2_reg;
  wire        stb_rise = stb_sync_reg[1] & ~stb_sync_reg[2];
  wire        fifo_in_ready;
  wire        fifo_valid;
  wire [9:0]  fifo_word;
  reg         pop;
  always @(posedge mclk) begin
    stb_sync_reg <= {stb_sync_reg[1:0], host_stb};
    clr_sync_reg <= {clr_sync_reg[0], external_clear_pin_n};
    word_s1_reg  <= {host_dc, host_rd, host_wdata};
    word_s2_reg  <= word_s1_reg;
  end
  lcdc_fifo #(.WIDTH(10), .DEPTH(32), .AW(5)) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (stb_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (word_s2_reg),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_word)
  );
  wire       w_dc = fifo_word[9];
  wire       w_rd = fifo_word[8];
  wire [7:0] w_d  = fifo_word[7:0];

  // ==========================================
  // decoder state
  localparam ST_IDLE = 4'b0001;
  localparam ST_ARG  = 4'b0010;
  localparam ST_RDW  = 4'b0100;
  localparam ST_INIT = 4'b1000;
  reg [3:0]  state_reg;
  reg [7:0]  op_reg;
  reg [7:0]  col_save_reg;
  reg        rmw_reg;
  reg        dummy_reg;
  reg        ind_on_reg;
  reg [9:0]  init_cnt_reg;
  wire       hard_clr = !rstn || !clr_sync_reg[1];
  wire [7:0] col_inc = (mem_addr == `LCDC_COL_MAX) ? mem_addr : mem_addr + 8'h01;

  always @* begin
    pop = fifo_valid && (state_reg == ST_IDLE || state_reg == ST_ARG);
  end

  always @(posedge mclk) begin
    if (hard_clr) begin
      state_reg <= ST_INIT;
      init_cnt_reg <= 10'h000;
      op_reg <= 8'h00;
      col_save_reg <= 8'h00;
      rmw_reg <= 1'b0;
      dummy_reg <= 1'b1;
      ind_on_reg <= 1'b0;
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
      host_busy <= 1'b1;
      mem_addr <= 8'h00;
      mem_page <= 4'h0;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      pwr_buffer <= 1'b0;
      pwr_regulator <= 1'b0;
      pwr_booster <= 1'b0;
      static_icon_drive <= 2'b00;
      sleep_mode <= 1'b0;
      standby_mode <= 1'b0;
      mux_ratio <= {1'b0, `LCDC_MUX_RST} + 7'h02;
      disp_offset <= 6'h00;
      start_line <= 6'h00;
      contrast <= `LCDC_CONTRAST_RST;
      bias_sel <= 2'b00;
      bias_alt <= 1'b0;
      bias_quarter <= 1'b0;
      temperature_slope <= 3'h0;
      osc_trim <= `LCDC_TRIM_RST;
      frame_phase <= `LCDC_PHASE_RST;
      internal_ladder_select <= `LCDC_LADDER_RST;
      disp_on <= 1'b0;
      entire_on <= 1'b0;
      disp_reverse <= 1'b0;
      seg_remap <= 1'b0;
      com_remap <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      host_rvalid <= 1'b0;
      // waiting for an argument byte is not busy, the host must send it
      host_busy <= (state_reg == ST_INIT) || (state_reg == ST_RDW) || !fifo_in_ready;
      // step the column one cycle after the write strobe, so the write lands at the old column
      if (mem_we)
        mem_addr <= col_inc;
      case (state_reg)
        ST_INIT: begin
          init_cnt_reg <= init_cnt_reg + 10'h001;
          if (init_cnt_reg == `LCDC_INIT_CYC - 1)
            state_reg <= ST_IDLE;
        end
        ST_RDW: begin
          host_rdata <= dummy_reg ? 8'h00 : mem_rdata;
          host_rvalid <= 1'b1;
          dummy_reg <= 1'b0;
          if (!rmw_reg && !dummy_reg)
            mem_addr <= col_inc;
          state_reg <= ST_IDLE;
        end
        ST_ARG: begin
          if (fifo_valid) begin
            state_reg <= ST_IDLE;
            case (op_reg)
              `LCDC_OP_CONTRAST: contrast <= w_d[5:0];
              `LCDC_OP_MUX: mux_ratio <= {1'b0, w_d[5:0]} + 7'h02;
              `LCDC_OP_BIASCFG: begin
                bias_sel <= w_d[1:0];
                temperature_slope <= w_d[4:2];
                osc_trim <= w_d[7:5];
              end
              `LCDC_OP_PHASE: frame_phase <= w_d[5:4];
              `LCDC_OP_OFFSET: disp_offset <= w_d[5:0];
              default: static_icon_drive <= w_d[1:0];
            endcase
          end
        end
        ST_IDLE: begin
          if (fifo_valid && w_dc && w_rd) begin
            mem_wdata <= mem_wdata;
            state_reg <= ST_RDW;
          end else if (fifo_valid && w_dc) begin
            mem_wdata <= w_d;
            mem_we <= 1'b1;
            dummy_reg <= 1'b1;
          end else if (fifo_valid && w_rd) begin
            host_rdata <= {host_busy, !seg_remap, !disp_on, 1'b0, `LCDC_ID_CODE};
            host_rvalid <= 1'b1;
          end else if (fifo_valid) begin
            op_reg <= w_d;
            casez (w_d)
              8'b0000????: begin
                mem_addr <= {mem_addr[7:4], w_d[3:0]};
                dummy_reg <= 1'b1;
              end
              8'b0001????: begin
                mem_addr <= {w_d[3:0], mem_addr[3:0]};
                dummy_reg <= 1'b1;
              end
              8'b00100???: internal_ladder_select <= w_d[2:0];
              8'b00101???: begin
                pwr_buffer <= w_d[0];
                pwr_regulator <= w_d[1];
                pwr_booster <= w_d[2];
              end
              8'b01??????: start_line <= w_d[5:0];
              8'b1010000?: seg_remap <= w_d[0];
              8'b1010001?: bias_alt <= w_d[0];
              8'b1010010?: begin
                entire_on <= w_d[0];
                if (w_d[0] && !disp_on) begin
                  sleep_mode <= !ind_on_reg;
                  standby_mode <= ind_on_reg;
                end else if (!w_d[0]) begin
                  sleep_mode <= 1'b0;
                  standby_mode <= 1'b0;
                end
              end
              8'b1010011?: disp_reverse <= w_d[0];
              8'b1010101?: bias_quarter <= w_d[0];
              8'b1010110?: begin
                ind_on_reg <= w_d[0];
                if (w_d[0])
                  state_reg <= ST_ARG;
                else
                  static_icon_drive <= 2'b00;
              end
              8'b1010111?: begin
                disp_on <= w_d[0];
                if (w_d[0]) begin
                  sleep_mode <= 1'b0;
                  standby_mode <= 1'b0;
                end
              end
              8'b1011????: begin
                mem_page <= w_d[3:0];
                dummy_reg <= 1'b1;
              end
              8'b1100????: com_remap <= w_d[3];
              8'b10000001, 8'b10101000, 8'b10101001, 8'b11010100, 8'b11010011:
                state_reg <= ST_ARG;
              `LCDC_OP_RMW_ON: begin
                rmw_reg <= 1'b1;
                col_save_reg <= mem_addr;
              end
              `LCDC_OP_RMW_OFF: begin
                rmw_reg <= 1'b0;
                if (rmw_reg)
                  mem_addr <= col_save_reg;
              end
              `LCDC_OP_SWRST: begin
                rmw_reg <= 1'b0;
                ind_on_reg <= 1'b0;
                static_icon_drive <= 2'b00;
                start_line <= 6'h00;
                mem_addr <= 8'h00;
                mem_page <= 4'h0;
                com_remap <= 1'b0;
                internal_ladder_select <= `LCDC_LADDER_RST;
                contrast <= `LCDC_CONTRAST_RST;
                if (standby_mode) begin
                  standby_mode <= 1'b0;
                  sleep_mode <= 1'b1;
                end
                init_cnt_reg <= 10'h000;
                state_reg <= ST_INIT;
              end
              default: op_reg <= op_reg;
            endcase
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // lcdc_decoder

/* File: lcdc_consts.vh */
// constants for the lcd command decoder
`ifndef LCDC_CONSTS_VH
`define LCDC_CONSTS_VH
`define LCDC_COL_MAX        8'h83
`define LCDC_CONTRAST_RST   6'h20
`define LCDC_LADDER_RST     3'h4
`define LCDC_TRIM_RST       3'h3
`define LCDC_PHASE_RST      2'h2
`define LCDC_MUX_RST        6'h3F
`define LCDC_ID_CODE        4'h5 // arbitrary value, not a real family code
`define LCDC_OP_CONTRAST    8'h81
`define LCDC_OP_MUX         8'hA8
`define LCDC_OP_BIASCFG     8'hA9
`define LCDC_OP_PHASE       8'hD4
`define LCDC_OP_OFFSET      8'hD3
`define LCDC_OP_NOP         8'hE3
`define LCDC_OP_RMW_ON      8'hE0
`define LCDC_OP_RMW_OFF     8'hEE
`define LCDC_OP_SWRST       8'hE2
`define LCDC_ST_BUSY        7
`define LCDC_ST_SEGNORM     6
`define LCDC_ST_DISPOFF     5
`define LCDC_ST_INIT        4
`define LCDC_INIT_NS        1000
`define LCDC_CLK_NS         20
`define LCDC_INIT_CYC       ((`LCDC_INIT_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)
`endif

/* File: lcdc_fifo.v */
// parameterised fifo between host port and command decoder
module lcdc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk,
  input  wire             rstn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp_reg;
  reg [AW:0]      rp_reg;
  wire            full  = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  wire            empty = (wp_reg == rp_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_reg[AW-1:0]];
  always @(posedge mclk) begin
    if (in_valid && !full)
      mem[wp_reg[AW-1:0]] <= in_data;
  end
  always @(posedge mclk) begin
    if (!rstn) begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wp_reg <= wp_reg + 1'b1;
      if (out_ready && !empty)
        rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule // lcdc_fifo

/* File: lcdc_decoder_properties.sv */
// checker for the lcd command decoder ports
module lcdc_props (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       host_rvalid,
  input wire logic       host_busy,
  input wire logic [7:0] mem_addr,
  input wire logic       mem_we,
  input wire logic [6:0] mux_ratio,
  input wire logic       sleep_mode,
  input wire logic       standby_mode,
  input wire logic       disp_on,
  input wire logic       entire_on,
  input wire logic [1:0] static_icon_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========
  // properties
  property p_col_sat; mem_addr <= 8'h83; endproperty
  property p_we_adv; mem_we && mem_addr < 8'h83 |=> mem_addr == $past(mem_addr) + 8'h01; endproperty
  property p_we_hold; mem_we && mem_addr == 8'h83 |=> mem_addr == 8'h83; endproperty
  property p_we_pulse; mem_we |=> !mem_we; endproperty
  property p_rv_pulse; host_rvalid |=> !host_rvalid; endproperty
  property p_mux; mux_ratio >= 7'd2 && mux_ratio <= 7'd65; endproperty
  property p_init; $rose(rstn) |-> host_busy [*8]; endproperty
  property p_sleep; $rose(sleep_mode) |-> !disp_on && entire_on && static_icon_drive == 2'h0;
  endproperty
  property p_stby; $rose(standby_mode) |-> !disp_on && entire_on && static_icon_drive != 2'h0;
  endproperty
  property p_excl; !(sleep_mode && standby_mode); endproperty
  a_col_sat: assert property (p_col_sat) else $error("column past end");
  a_we_adv: assert property (p_we_adv) else $error("no column step");
  a_we_hold: assert property (p_we_hold) else $error("column wrapped");
  a_we_pulse: assert property (p_we_pulse) else $error("write held");
  a_rv_pulse: assert property (p_rv_pulse) else $error("read valid held");
  a_mux: assert property (p_mux) else $error("mux out of range");
  a_init: assert property (p_init) else $error("busy low in init");
  a_sleep: assert property (p_sleep) else $error("bad sleep entry");
  a_stby: assert property (p_stby) else $error("bad standby entry");
  a_excl: assert property (p_excl) else $error("both save modes");
  c_sleep: cover property ($rose(sleep_mode));
  c_stby: cover property ($rose(standby_mode));
  c_sat: cover property (mem_we && mem_addr == 8'h83);
endmodule // lcdc_props
bind lcdc_decoder lcdc_props i_lcdc_props (.*);

/* File: lcdc_mem_model.sv */
// display memory model at the decoder far side
module lcdc_mem_model (
  input wire logic       mclk,
  input wire logic [3:0] mem_page,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic       mem_we,
  output logic     [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:4095];
  // unwritten cells hold a pattern, not zero
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'h5A ^ i[7:0];
  always @(posedge mclk) if (mem_we) mem[{mem_page, mem_addr}] <= mem_wdata;
  assign mem_rdata = mem[{mem_page, mem_addr}];
endmodule // lcdc_mem_model

/* File: testbench.sv */
// self-checking bench for the lcd command decoder
`include "lcdc_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rstn = 0, external_clear_pin_n = 1, host_stb = 0, host_dc = 0, host_rd = 0;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] host_rdata, mem_addr, mem_wdata, mem_rdata, r, v;
  logic host_rvalid, host_busy, mem_we, pwr_buffer, pwr_regulator, pwr_booster, sleep_mode;
  logic standby_mode, bias_alt, bias_quarter, disp_on, entire_on, disp_reverse, seg_remap, com_remap;
  logic [3:0] mem_page;
  logic [1:0] static_icon_drive, bias_sel, frame_phase;
  logic [6:0] mux_ratio;
  logic [5:0] disp_offset, start_line, contrast;
  logic [2:0] temperature_slope, osc_trim, internal_ladder_select;
  int err_count = 0, tests_run = 0, col = 0, ofs;
  logic [7:0] mm [int];
  lcdc_decoder i_lcdc_decoder (.*);
  lcdc_mem_model i_lcdc_mem_model (.*);
  always #10 mclk = ~mclk;
  // ==========
  // tasks
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic dc, input logic rd, input logic [7:0] d);
    int n;
    r = 8'hxx;
    @(posedge mclk);
    host_dc <= dc;
    host_rd <= rd;
    host_wdata <= d;
    repeat (3) @(posedge mclk);
    host_stb <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk);
      if (n == 3) host_stb <= 1'b0;
      if (host_rvalid === 1'b1) r = host_rdata;
      if (n > 6 && host_busy === 1'b0) break;
    end
    if (n == 200) begin
      err_count++;
      print_verdict;
    end
  endtask
  task automatic cmd(input logic [7:0] d);
    xfer(1'b0, 1'b0, d);
  endtask
  task automatic setcol(input logic [7:0] c);
    cmd({4'h0, c[3:0]});
    cmd({4'h1, c[7:4]});
    col = c;
    chk(mem_addr, col);
  endtask
  task automatic wr(input logic [7:0] d);
    mm[col] = d;
    xfer(1'b1, 1'b0, d);
    if (col < 131) col++;
    chk(mem_addr, col);
  endtask
  // ==========
  // main sequence
  initial begin
    void'($urandom(43266));
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    cmd(8'hE3);
    chk({contrast, osc_trim, frame_phase, mux_ratio, disp_offset},
        {6'h20, 3'h3, 2'h2, 7'd65, 6'h00});
    chk({pwr_booster, pwr_regulator, pwr_buffer, static_icon_drive, bias_quarter},
        0);
    xfer(1'b0, 1'b1, 8'h00);
    chk(r, {4'h6, `LCDC_ID_CODE});
    $display("test reset and status done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      cmd(8'hA8);
      cmd({2'b00, v[5:0]});
      chk(mux_ratio, v[5:0] + 7'd2);
      ofs = (63 - v[5:0]) / 2;
      cmd(8'hD3);
      cmd({2'b00, ofs[5:0]});
      chk(disp_offset, ofs);
      cmd(8'hA9);
      cmd(v);
      chk({osc_trim, temperature_slope, bias_sel}, v);
      cmd(8'hD4);
      cmd({2'b00, v[1:0], 4'h0});
      chk(frame_phase, v[1:0]);
      cmd(8'h81);
      cmd({2'b00, v[7:2]});
      chk(contrast, v[7:2]);
      cmd({5'h05, v[2:0]});
      chk({pwr_booster, pwr_regulator, pwr_buffer}, v[2:0]);
      cmd({2'b01, v[5:0]});
      chk(start_line, v[5:0]);
      cmd({7'h55, v[0]});
      chk(bias_quarter, v[0]);
      cmd(8'hAD);
      cmd({6'h00, i[1:0]});
      chk(static_icon_drive, i[1:0]);
      cmd(8'hE3);
      chk({contrast, start_line, mux_ratio}, {v[7:2], v[5:0], v[5:0] + 7'd2});
    end
    cmd(8'hA1);
    cmd(8'hA3);
    cmd(8'hA7);
    cmd(8'hC8);
    cmd({5'h04, v[2:0]});
    cmd(8'hAF);
    chk({seg_remap, bias_alt, disp_reverse, com_remap, disp_on, internal_ladder_select},
        {5'h1F, v[2:0]});
    xfer(1'b0, 1'b1, 8'h00);
    chk(r, {4'h0, `LCDC_ID_CODE});
    cmd(8'hAC);
    chk(static_icon_drive, 0);
    $display("test configuration done");
    cmd(8'hB1);
    setcol(8'h81);
    repeat (3) wr(8'($urandom));
    setcol(8'h81);
    xfer(1'b1, 1'b1, 8'h00);
    chk({r, mem_addr}, {8'h00, 8'h81});
    repeat (3) begin
      xfer(1'b1, 1'b1, 8'h00);
      chk(r, mm[col]);
      if (col < 131) col++;
      chk(mem_addr, col);
    end
    setcol(8'h40);
    wr(8'($urandom));
    setcol(8'h40);
    xfer(1'b1, 1'b1, 8'h00);
    cmd(8'hE0);
    repeat (2) begin
      xfer(1'b1, 1'b1, 8'h00);
      chk({r, mem_addr}, {mm[64], 8'h40});
    end
    wr(8'($urandom));
    cmd(8'hEE);
    chk(mem_addr, 8'h40);
    $display("test memory access done");
    cmd(8'hAE);
    cmd(8'hA5);
    chk({sleep_mode, standby_mode, entire_on, disp_on}, 4'b1010);
    cmd(8'hAF);
    cmd(8'hA4);
    chk({sleep_mode, standby_mode, entire_on, disp_on}, 4'b0001);
    cmd(8'hAD);
    cmd(8'h03);
    cmd(8'hAE);
    cmd(8'hA5);
    chk({sleep_mode, standby_mode}, 2'b01);
    // soft reset from standby falls into sleep and restores defaults
    cmd(8'hE2);
    chk({sleep_mode, standby_mode, contrast, start_line, static_icon_drive},
        {2'b10, `LCDC_CONTRAST_RST, 6'h00, 2'b00});
    chk({internal_ladder_select, mem_addr, com_remap},
        {`LCDC_LADDER_RST, 8'h00, 1'b0});
    $display("test power save done");
    external_clear_pin_n <= 1'b0;
    repeat (5) @(posedge mclk);
    external_clear_pin_n <= 1'b1;
    cmd(8'hE3);
    chk({contrast, mem_addr, sleep_mode, standby_mode}, {6'h20, 8'h00, 2'b00});
    $display("test pin reset done");
    print_verdict;
  end
endmodule // testbench
